// ---- gpom_consts.vh ----
// Constants for the general pin seven output source multiplexer
`ifndef GPOM_CONSTS_VH
`define GPOM_CONSTS_VH

// Register map
`define GPOM_ADDR_W 8
`define GPOM_CTL_ADDR 8'h17
`define GPOM_CTL_RESET 8'h00
`define GPOM_STAT_ADDR 8'h80

// Control register field positions
`define GPOM_SEL_HI 7
`define GPOM_SEL_LO 5
`define GPOM_SRC_HI 4
`define GPOM_SRC_LO 2
`define GPOM_VAL_BIT 1
`define GPOM_EN_BIT 0

// Source codes
`define GPOM_SRC_DEV 3'h4
`define GPOM_SRC_TX 3'h6

// Selection codes
`define GPOM_SEL_0 3'h0
`define GPOM_SEL_1 3'h1
`define GPOM_SEL_2 3'h2
`define GPOM_SEL_3 3'h3
`define GPOM_SEL_4 3'h4
`define GPOM_SEL_5 3'h5
`define GPOM_SEL_6 3'h6
`define GPOM_SEL_7 3'h7

`endif

// ---- gpom_sync2.v ----
// Two-flop synchroniser for a bundle of asynchronous levels
`timescale 1ns/100ps
module gpom_sync2 #(
   parameter WIDTH = 8
) (
   // Clock and reset
   input wire core_clk_in,
   input wire rst_n_in,
   // Levels
   input wire [WIDTH-1:0] async_in,
   output wire [WIDTH-1:0] sync_out
);
   reg [WIDTH-1:0] meta_r;
   reg [WIDTH-1:0] stable_r;

   // First stage is read only by the second stage
   always @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         meta_r <= {WIDTH{1'b0}};
         stable_r <= {WIDTH{1'b0}};
      end else begin
         meta_r <= async_in;
         stable_r <= meta_r;
      end
   end

   assign sync_out = stable_r;
endmodule // gpom_sync2

// ---- gpom_pin7_mux.v ----
// Output source multiplexer and drive control for general pin seven
`timescale 1ns/100ps
`include "gpom_consts.vh"

module gpom_pin7_mux #(
   parameter NPORTS = 4
) (
   // Clock and reset
   input wire core_clk_in,
   input wire rst_n_in,
   // Register port
   input wire [`GPOM_ADDR_W-1:0] reg_addr_in,
   input wire [7:0] reg_wdata_in,
   input wire reg_wr_in,
   input wire reg_rd_in,
   output reg [7:0] reg_rdata_out,
   // Receive port status, four forwarded signals per port
   input wire [4*NPORTS-1:0] rx_remote_in,
   input wire [NPORTS-1:0] rx_lock_in,
   input wire [NPORTS-1:0] rx_pass_in,
   input wire [NPORTS-1:0] rx_fv_in,
   input wire [NPORTS-1:0] rx_lv_in,
   input wire [NPORTS-1:0] rx_port_en_in,
   input wire [NPORTS-1:0] tx_port_sel_in,
   // Device and transmit status
   input wire camera_trigger_signal_in,
   input wire tx_fv_in,
   input wire tx_lv_in,
   input wire tx_synced_in,
   input wire tx_irq_in,
   // General pin seven drive
   output reg general_pin_seven_out,
   output reg general_pin_seven_oe_out
);
   localparam SW = 8 * NPORTS + 5;

   reg [7:0] pin7_output_control_r;
   reg level_nxt;
   wire [SW-1:0] raw_w;
   wire [SW-1:0] syn_w;
   wire [2:0] pin7_signal_select;
   wire [2:0] pin7_source_select;
   wire pin7_local_value;
   wire pin7_drive_enable;
   wire [4*NPORTS-1:0] s_remote;
   wire [NPORTS-1:0] s_lock;
   wire [NPORTS-1:0] s_pass;
   wire [NPORTS-1:0] s_fv;
   wire [NPORTS-1:0] s_lv;
   wire s_trig;
   wire s_tfv;
   wire s_tlv;
   wire s_sync;
   wire s_irq;
   wire [1:0] port_idx;
   wire any_lock_en;
   wire all_pass_en;
   wire all_pass_sel;
   wire any_pass_sel;

   // Status arrives from other logic and pins; resynchronise all but the port enables and transmit selection
   assign raw_w = {rx_remote_in, rx_lock_in, rx_pass_in, rx_fv_in, rx_lv_in,
                   camera_trigger_signal_in, tx_fv_in, tx_lv_in, tx_synced_in, tx_irq_in};

   gpom_sync2 #(
      .WIDTH(SW)
   ) u_sync (
      .core_clk_in(core_clk_in),
      .rst_n_in(rst_n_in),
      .async_in(raw_w),
      .sync_out(syn_w)
   );

   assign {s_remote, s_lock, s_pass, s_fv, s_lv, s_trig, s_tfv, s_tlv, s_sync, s_irq} = syn_w;

   // Control register fields
   assign pin7_signal_select = pin7_output_control_r[`GPOM_SEL_HI:`GPOM_SEL_LO];
   assign pin7_source_select = pin7_output_control_r[`GPOM_SRC_HI:`GPOM_SRC_LO];
   assign pin7_local_value = pin7_output_control_r[`GPOM_VAL_BIT];
   assign pin7_drive_enable = pin7_output_control_r[`GPOM_EN_BIT];
   assign port_idx = pin7_source_select[1:0];

   // Aggregates; port enables and transmit selection are same-domain configuration
   assign any_lock_en = |(s_lock & rx_port_en_in);
   assign all_pass_en = &(s_pass | ~rx_port_en_in);
   assign all_pass_sel = &(s_pass | ~tx_port_sel_in);
   assign any_pass_sel = |(s_pass & tx_port_sel_in);

   // Register write and read-back, data one cycle after the strobe
   always @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         pin7_output_control_r <= `GPOM_CTL_RESET;
         reg_rdata_out <= 8'h00;
      end else begin
         if (reg_wr_in && reg_addr_in == `GPOM_CTL_ADDR) begin
            pin7_output_control_r <= reg_wdata_in;
         end
         if (reg_rd_in) begin
            if (reg_addr_in == `GPOM_CTL_ADDR) begin
               reg_rdata_out <= pin7_output_control_r;
            end else if (reg_addr_in == `GPOM_STAT_ADDR) begin
               reg_rdata_out <= {6'h00, general_pin_seven_oe_out, general_pin_seven_out};
            end else begin
               reg_rdata_out <= 8'h00;
            end
         end else begin
            reg_rdata_out <= 8'h00;
         end
      end
   end

   // Source and selection decode
   always @* begin
      level_nxt = 1'b0;
      if (!pin7_source_select[2]) begin
         case (pin7_signal_select)
            `GPOM_SEL_0, `GPOM_SEL_1, `GPOM_SEL_2, `GPOM_SEL_3: begin
               level_nxt = s_remote[{port_idx, pin7_signal_select[1:0]}];
            end
            `GPOM_SEL_4: begin
               level_nxt = s_lock[port_idx];
            end
            `GPOM_SEL_5: begin
               level_nxt = s_pass[port_idx];
            end
            `GPOM_SEL_6: begin
               level_nxt = s_fv[port_idx];
            end
            default: begin
               level_nxt = s_lv[port_idx];
            end
         endcase
      end else if (pin7_source_select == `GPOM_SRC_DEV) begin
         case (pin7_signal_select)
            `GPOM_SEL_0: begin
               level_nxt = pin7_local_value;
            end
            `GPOM_SEL_1: begin
               level_nxt = any_lock_en;
            end
            `GPOM_SEL_2, `GPOM_SEL_3: begin
               level_nxt = all_pass_en;
            end
            `GPOM_SEL_4: begin
               level_nxt = s_trig;
            end
            default: begin
               level_nxt = 1'b0;
            end
         endcase
      end else if (pin7_source_select == `GPOM_SRC_TX) begin
         case (pin7_signal_select)
            `GPOM_SEL_0: begin
               level_nxt = all_pass_sel;
            end
            `GPOM_SEL_1: begin
               level_nxt = any_pass_sel;
            end
            `GPOM_SEL_2: begin
               level_nxt = s_tfv;
            end
            `GPOM_SEL_3: begin
               level_nxt = s_tlv;
            end
            `GPOM_SEL_4: begin
               level_nxt = s_sync;
            end
            `GPOM_SEL_5: begin
               level_nxt = s_irq;
            end
            default: begin
               level_nxt = 1'b0;
            end
         endcase
      end else begin
         level_nxt = 1'b0;
      end
   end

   // Registered pin drive; level forced low while disabled
   always @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         general_pin_seven_out <= 1'b0;
         general_pin_seven_oe_out <= 1'b0;
      end else begin
         general_pin_seven_oe_out <= pin7_drive_enable;
         general_pin_seven_out <= pin7_drive_enable & level_nxt;
      end
   end
endmodule // gpom_pin7_mux

// ---- gpom_board.sv ----
// Board side of general pin seven: pull-up resolves the undriven line
`timescale 1ns/100ps
module gpom_board (
   // Pin from the device
   input wire pin_in,
   input wire oe_in,
   // Level seen on the board
   output wire line_out
);
   // Released line floats up to the pull-up level
   assign line_out = oe_in ? pin_in : 1'b1;
endmodule // gpom_board

// ---- gpom_pin7_mux_monitor.sv ----
// Checker for the pin seven multiplexer ports
`timescale 1ns/100ps
`include "gpom_consts.vh"
module gpom_pin7_mux_chk #(
   parameter NPORTS = 4
) (
   // Clock and reset
   input wire core_clk_in,
   input wire rst_n_in,
   // Register port
   input wire [7:0] reg_addr_in,
   input wire [7:0] reg_wdata_in,
   input wire reg_wr_in,
   input wire reg_rd_in,
   input wire [7:0] reg_rdata_out,
   // Status and pin
   input wire [NPORTS-1:0] rx_lock_in,
   input wire general_pin_seven_out,
   input wire general_pin_seven_oe_out
);
   reg [7:0] ctl_r;
   wire pin = general_pin_seven_out;
   wire oe = general_pin_seven_oe_out;
   // Shadow of the control register
   always @(posedge core_clk_in) begin
      if (!rst_n_in) ctl_r <= 8'h00;
      else if (reg_wr_in && reg_addr_in == `GPOM_CTL_ADDR) ctl_r <= reg_wdata_in;
   end
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (!rst_n_in);
   chk_rdata_idle: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 8'h00)
      else $error("read data not idle");
   chk_ctl_readback: assert property (reg_rd_in && reg_addr_in == `GPOM_CTL_ADDR |=> reg_rdata_out == $past(ctl_r))
      else $error("control readback wrong");
   chk_unmapped_zero: assert property (reg_rd_in && reg_addr_in != `GPOM_CTL_ADDR && reg_addr_in != `GPOM_STAT_ADDR
      |=> reg_rdata_out == 8'h00) else $error("unmapped read not zero");
   chk_status_read: assert property (reg_rd_in && reg_addr_in == `GPOM_STAT_ADDR
      |=> reg_rdata_out == {6'h00, $past(oe), $past(pin)}) else $error("status read wrong");
   chk_oe_follow: assert property ($past(rst_n_in) |-> oe == $past(ctl_r[0]))
      else $error("drive enable wrong");
   chk_disabled_low: assert property (!oe |-> !pin) else $error("pin high while disabled");
   chk_local_value: assert property ($past(rst_n_in) && $past(ctl_r[7:2]) == 6'h04
      |-> pin == &$past(ctl_r[1:0])) else $error("local value wrong");
   chk_reserved_src: assert property ($past(rst_n_in) && $past(ctl_r[2]) && $past(ctl_r[4]) |-> !pin)
      else $error("reserved source drives");
   chk_reserved_sel: assert property ($past(rst_n_in) && ($past(ctl_r[4:2]) == `GPOM_SRC_DEV && $past(ctl_r[7:5]) > 4
      || $past(ctl_r[4:2]) == `GPOM_SRC_TX && $past(ctl_r[7:5]) > 5) |-> !pin) else $error("reserved select drives");
   chk_lock_latency: assert property ($past(rst_n_in, 3) && $past(rst_n_in, 2) && $past(rst_n_in)
      && $past(ctl_r) == 8'h83 |-> pin == $past(rx_lock_in[0], 3)) else $error("lock path wrong");
   cover property (reg_wr_in && reg_addr_in == `GPOM_CTL_ADDR);
   cover property ($past(ctl_r) == 8'h83 && pin);
   cover property (reg_rd_in && reg_addr_in == `GPOM_STAT_ADDR);
endmodule // gpom_pin7_mux_chk
bind gpom_pin7_mux gpom_pin7_mux_chk #(.NPORTS(NPORTS)) i_gpom_pin7_mux_chk (.core_clk_in, .rst_n_in, .reg_addr_in,
   .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .rx_lock_in, .general_pin_seven_out, .general_pin_seven_oe_out);

// ---- gpom_pin7_mux_tb.sv ----
// Testbench for the pin seven output multiplexer
`timescale 1ns/100ps
`include "gpom_consts.vh"
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin miscompares++; \
   $display("[ERR] %s exp %h got %h", n, e, g); end end
module gpom_pin7_mux_tb;
   reg core_clk_in = 1'b0;
   reg rst_n_in = 1'b0;
   reg [7:0] addr = 8'h00;
   reg [7:0] wdata = 8'h00;
   reg [7:0] rd_val = 8'h00;
   reg wr = 1'b0;
   reg rd = 1'b0;
   reg [44:0] st = 45'h0000_0000_0000;
   wire [7:0] rdata;
   wire pin, oe, line;
   int miscompares = 0;
   int samples_checked = 0;
   int p, c;
   // Status bundle: remote, lock, pass, fv, lv, enable, tx select, trigger, tx fv, lv, synced, irq
   gpom_pin7_mux i_gpom_pin7_mux (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .reg_addr_in(addr),
      .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .rx_remote_in(st[44:29]),
      .rx_lock_in(st[28:25]), .rx_pass_in(st[24:21]), .rx_fv_in(st[20:17]), .rx_lv_in(st[16:13]),
      .rx_port_en_in(st[12:9]), .tx_port_sel_in(st[8:5]), .camera_trigger_signal_in(st[4]), .tx_fv_in(st[3]),
      .tx_lv_in(st[2]), .tx_synced_in(st[1]), .tx_irq_in(st[0]), .general_pin_seven_out(pin),
      .general_pin_seven_oe_out(oe));
   gpom_board i_gpom_board (.pin_in(pin), .oe_in(oe), .line_out(line));
   // Clock at 100 MHz
   initial forever #5 core_clk_in = ~core_clk_in;
   // Bus cycles
   task wr_reg(input [7:0] a, input [7:0] d);
      @(posedge core_clk_in);
      addr <= a; wdata <= d; wr <= 1'b1;
      @(posedge core_clk_in);
      wr <= 1'b0;
   endtask
   task rd_reg(input [7:0] a);
      @(posedge core_clk_in);
      addr <= a; rd <= 1'b1;
      @(posedge core_clk_in);
      rd <= 1'b0;
      #1 rd_val = rdata;
   endtask
   // Expected pin level for a control value and status bundle
   function f(input [7:0] k, input [44:0] s);
      reg [2:0] sl, sr;
      begin
         sl = k[7:5]; sr = k[4:2]; f = 1'b0;
         if (sr < 3'h4) f = sl[2] ? s[25 - 4 * sl[1:0] + sr] : s[29 + 4 * sr + sl];
         else if (sr == `GPOM_SRC_DEV) case (sl)
            0: f = k[1]; 1: f = |(s[28:25] & s[12:9]); 2, 3: f = &(s[24:21] | ~s[12:9]); 4: f = s[4];
            default: f = 1'b0; endcase
         else if (sr == `GPOM_SRC_TX) case (sl)
            0: f = &(s[24:21] | ~s[8:5]); 1: f = |(s[24:21] & s[8:5]); 2: f = s[3]; 3: f = s[2];
            4: f = s[1]; 5: f = s[0]; default: f = 1'b0; endcase
         f = f & k[0];
      end
   endfunction
   function [44:0] pat(input int k);
      pat = (k == 1) ? ~45'h0A5C_3B6E_9D27 : (k == 2) ? 45'h0A5D_FB6E_9D27 : 45'h0A5C_3B6E_9D27;
   endfunction
   task final_report;
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // Watchdog
   initial begin
      #200000;
      miscompares++;
      final_report;
   end
   // Test sequence
   initial begin
      repeat (4) @(posedge core_clk_in);
      rst_n_in <= 1'b1;
      rd_reg(`GPOM_CTL_ADDR); `CHK("ctl reset", `GPOM_CTL_RESET, rd_val)
      `CHK("oe reset", 1'b0, oe)
      wr_reg(`GPOM_CTL_ADDR, 8'hA5); rd_reg(`GPOM_CTL_ADDR); `CHK("ctl rw", 8'hA5, rd_val)
      rd_reg(8'h33); `CHK("unmapped", 8'h00, rd_val)
      // Every source and selection code over three status patterns
      for (p = 0; p < 3; p++) for (c = 0; c < 64; c++) begin
         st <= pat(p);
         wr_reg(`GPOM_CTL_ADDR, {c[5:0], p[0], 1'b1});
         repeat (5) @(posedge core_clk_in);
         `CHK("pin", f({c[5:0], p[0], 1'b1}, pat(p)), line)
      end
      wr_reg(`GPOM_CTL_ADDR, 8'h12); repeat (3) @(posedge core_clk_in);
      `CHK("released line", 1'b1, line)
      `CHK("oe off", 1'b0, oe)
      wr_reg(`GPOM_CTL_ADDR, 8'h13); repeat (3) @(posedge core_clk_in);
      rd_reg(`GPOM_STAT_ADDR); `CHK("status", 8'h03, rd_val)
      final_report;
   end
endmodule // gpom_pin7_mux_tb
